/* core/ddim_pkg.sv */
package ddim_pkg;

    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 12;
    localparam int NUM_TYPES = 3;
    localparam int NUM_MASKS = 6;

    // Schedule type index; the AND mask of a type sits AND_BASE above its OR mask
    localparam int TYPE_ISO   = 0;
    localparam int TYPE_INTR  = 1;
    localparam int TYPE_ASYNC = 2;
    localparam int AND_BASE   = 3;

    localparam logic [ADDR_W-1:0] ISO_OR_OFFS        = 12'h318;
    localparam logic [ADDR_W-1:0] INTR_OR_OFFS       = 12'h31C;
    localparam logic [ADDR_W-1:0] ASYNC_OR_OFFS      = 12'h320;
    localparam logic [ADDR_W-1:0] ISO_AND_OFFS       = 12'h324;
    localparam logic [ADDR_W-1:0] INTR_AND_OFFS      = 12'h328;
    localparam logic [ADDR_W-1:0] ASYNC_AND_OFFS     = 12'h32C;
    localparam logic [ADDR_W-1:0] GROUP_STATUS_OFFS  = 12'h330;
    localparam logic [ADDR_W-1:0] ISO_DONE_OFFS      = 12'h334;
    localparam logic [ADDR_W-1:0] INTR_DONE_OFFS     = 12'h338;
    localparam logic [ADDR_W-1:0] ASYNC_DONE_OFFS    = 12'h33C;

    localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] DONE_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h00000000;

    // Group status word layout, three bits per OR, AND and IRQ field, one per schedule type, plus one any-request bit
    localparam int STAT_OR_LSB  = 0;
    localparam int STAT_AND_LSB = 4;
    localparam int STAT_IRQ_LSB = 8;
    localparam int STAT_ANY_BIT = 12;

endpackage

/* core/ddim_mask_bank.sv */
`timescale 1ns/10ps
module ddim_mask_bank #(
    parameter int DATA_W    = ddim_pkg::DATA_W,
    parameter int NUM_MASKS = ddim_pkg::NUM_MASKS
) (
    input  wire logic                                core_clk,
    input  wire logic                                reset_n,
    input  wire logic                                clk_en,
    input  wire logic [NUM_MASKS-1:0]                wr_stb,
    input  wire logic [DATA_W-1:0]                   wdata,
    output logic      [NUM_MASKS-1:0][DATA_W-1:0]    mask
);
    import ddim_pkg::*;

    typedef struct packed {
        logic [NUM_MASKS-1:0][DATA_W-1:0] mask;
    } ddim_bank_state_t;

    ddim_bank_state_t state_r;
    ddim_bank_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        for (int i = 0; i < NUM_MASKS; i++) begin
            if (wr_stb[i]) begin
                state_nxt.mask[i] = wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '{mask: {NUM_MASKS{MASK_RESET}}};
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign mask = state_r.mask;

endmodule

/* core/ddim_group_eval.sv */
`timescale 1ns/10ps
module ddim_group_eval #(
    parameter int DATA_W = ddim_pkg::DATA_W
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic [DATA_W-1:0] or_mask,
    input  wire logic [DATA_W-1:0] and_mask,
    input  wire logic [DATA_W-1:0] done_map,
    input  wire logic              irq_enable,
    output logic                   or_hit,
    output logic                   and_hit,
    output logic                   irq_req
);
    import ddim_pkg::*;

    typedef struct packed {
        logic or_hit;
        logic and_hit;
        logic irq_req;
    } ddim_eval_state_t;

    ddim_eval_state_t state_r;
    ddim_eval_state_t state_nxt;
    logic             or_now;
    logic             and_now;

    // Any OR-selected descriptor done; all AND-selected done, empty AND never fires
    assign or_now  = |(or_mask & done_map);
    assign and_now = (|and_mask) && ((and_mask & done_map) == and_mask);

    always_comb begin
        state_nxt         = state_r;
        state_nxt.or_hit  = or_now;
        state_nxt.and_hit = and_now;
        state_nxt.irq_req = irq_enable && (or_now || and_now);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign or_hit  = state_r.or_hit;
    assign and_hit = state_r.and_hit;
    assign irq_req = state_r.irq_req;

endmodule

/* core/ddim_irq_masks.sv */
`timescale 1ns/10ps
// Functional notes
// - Isochronous OR mask, 32 bits, reset zero; bit n selects isochronous descriptor n.
// - Interrupt-schedule OR mask, 32 bits, reset zero; bit n selects descriptor n.
// - Asynchronous OR mask, 32 bits, reset zero; bit n selects descriptor n.
// - Isochronous AND mask, 32 bits, reset zero; bit n selects descriptor n.
// - Interrupt-schedule AND mask, 32 bits, reset zero; bit n selects descriptor n.
// - Asynchronous AND mask, 32 bits, reset zero; bit n selects descriptor n.
// - Each mask bit qualifies exactly one descriptor done flag of its type.
// - Per-type enable bit gates interrupt assertion; zero means no interrupt.
// - Descriptor done flags feed the done map used for mask evaluation.
module ddim_irq_masks #(
    parameter int DATA_W    = ddim_pkg::DATA_W,
    parameter int ADDR_W    = ddim_pkg::ADDR_W,
    parameter int NUM_TYPES = ddim_pkg::NUM_TYPES
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    input  wire logic                  reg_cs,
    input  wire logic                  reg_wr_en,
    input  wire logic                  reg_rd_en,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [DATA_W-1:0]     reg_wdata,
    output logic      [DATA_W-1:0]     reg_rdata,
    output logic                       reg_rd_valid,
    input  wire logic [DATA_W-1:0]     iso_done_map,
    input  wire logic [DATA_W-1:0]     intr_done_map,
    input  wire logic [DATA_W-1:0]     async_done_map,
    input  wire logic                  iso_group_irq_enable,
    input  wire logic                  intr_group_irq_enable,
    input  wire logic                  async_group_irq_enable,
    output logic      [NUM_TYPES-1:0]  group_irq_req,
    output logic                       group_irq
);
    import ddim_pkg::*;

    localparam int NUM_MASK_REGS = 2 * NUM_TYPES;

    typedef struct packed {
        logic [NUM_TYPES-1:0][DATA_W-1:0] done_map;
        logic [DATA_W-1:0]                rdata;
        logic                             rd_valid;
    } ddim_top_state_t;

    ddim_top_state_t                        state_r;
    ddim_top_state_t                        state_nxt;
    logic [NUM_MASK_REGS-1:0]               wr_stb;
    logic [NUM_MASK_REGS-1:0][DATA_W-1:0]   mask;
    logic [NUM_MASK_REGS-1:0][ADDR_W-1:0]   mask_offs;
    logic [NUM_TYPES-1:0][DATA_W-1:0]       done_in;
    logic [NUM_TYPES-1:0]                   irq_enable;
    logic [NUM_TYPES-1:0]                   or_hit;
    logic [NUM_TYPES-1:0]                   and_hit;
    logic [NUM_TYPES-1:0]                   irq_req;
    logic [DATA_W-1:0]                      status_word;
    logic                                   wr_take;
    logic                                   rd_take;

    assign mask_offs[TYPE_ISO]              = ISO_OR_OFFS;
    assign mask_offs[TYPE_INTR]             = INTR_OR_OFFS;
    assign mask_offs[TYPE_ASYNC]            = ASYNC_OR_OFFS;
    assign mask_offs[AND_BASE + TYPE_ISO]   = ISO_AND_OFFS;
    assign mask_offs[AND_BASE + TYPE_INTR]  = INTR_AND_OFFS;
    assign mask_offs[AND_BASE + TYPE_ASYNC] = ASYNC_AND_OFFS;

    assign done_in[TYPE_ISO]   = iso_done_map;
    assign done_in[TYPE_INTR]  = intr_done_map;
    assign done_in[TYPE_ASYNC] = async_done_map;

    assign irq_enable[TYPE_ISO]   = iso_group_irq_enable;
    assign irq_enable[TYPE_INTR]  = intr_group_irq_enable;
    assign irq_enable[TYPE_ASYNC] = async_group_irq_enable;

    assign wr_take = reg_cs && reg_wr_en;
    assign rd_take = reg_cs && reg_rd_en && !reg_wr_en;

    // Full-word write strobe for each mask register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MASK_REGS; gi++) begin : g_stb
            assign wr_stb[gi] = wr_take && (reg_addr == mask_offs[gi]);
        end
    endgenerate

    ddim_mask_bank #(
        .DATA_W    (DATA_W),
        .NUM_MASKS (NUM_MASK_REGS)
    ) u_bank (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .wr_stb   (wr_stb),
        .wdata    (reg_wdata),
        .mask     (mask)
    );

    // One evaluator per schedule type, each bit of its masks against its own done map
    generate
        for (gi = 0; gi < NUM_TYPES; gi++) begin : g_eval
            ddim_group_eval #(
                .DATA_W (DATA_W)
            ) u_eval (
                .core_clk   (core_clk),
                .reset_n    (reset_n),
                .clk_en     (clk_en),
                .or_mask    (mask[gi]),
                .and_mask   (mask[AND_BASE + gi]),
                .done_map   (state_r.done_map[gi]),
                .irq_enable (irq_enable[gi]),
                .or_hit     (or_hit[gi]),
                .and_hit    (and_hit[gi]),
                .irq_req    (irq_req[gi])
            );
        end
    endgenerate

    always_comb begin
        status_word = RDATA_NONE;
        status_word[STAT_OR_LSB  +: NUM_TYPES] = or_hit;
        status_word[STAT_AND_LSB +: NUM_TYPES] = and_hit;
        status_word[STAT_IRQ_LSB +: NUM_TYPES] = irq_req;
        status_word[STAT_ANY_BIT]              = |irq_req;
    end

    always_comb begin
        state_nxt          = state_r;
        state_nxt.done_map = done_in;
        state_nxt.rd_valid = rd_take;
        if (rd_take) begin
            case (reg_addr)
                ISO_OR_OFFS: begin
                    state_nxt.rdata = mask[TYPE_ISO];
                end
                INTR_OR_OFFS: begin
                    state_nxt.rdata = mask[TYPE_INTR];
                end
                ASYNC_OR_OFFS: begin
                    state_nxt.rdata = mask[TYPE_ASYNC];
                end
                ISO_AND_OFFS: begin
                    state_nxt.rdata = mask[AND_BASE + TYPE_ISO];
                end
                INTR_AND_OFFS: begin
                    state_nxt.rdata = mask[AND_BASE + TYPE_INTR];
                end
                ASYNC_AND_OFFS: begin
                    state_nxt.rdata = mask[AND_BASE + TYPE_ASYNC];
                end
                GROUP_STATUS_OFFS: begin
                    state_nxt.rdata = status_word;
                end
                ISO_DONE_OFFS: begin
                    state_nxt.rdata = state_r.done_map[TYPE_ISO];
                end
                INTR_DONE_OFFS: begin
                    state_nxt.rdata = state_r.done_map[TYPE_INTR];
                end
                ASYNC_DONE_OFFS: begin
                    state_nxt.rdata = state_r.done_map[TYPE_ASYNC];
                end
                default: begin
                    state_nxt.rdata = RDATA_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '{done_map: {NUM_TYPES{DONE_RESET}}, rdata: RDATA_NONE, rd_valid: 1'b0};
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata     = state_r.rdata;
    assign reg_rd_valid  = state_r.rd_valid;
    assign group_irq_req = irq_req;
    assign group_irq     = |irq_req;

    // Checks on register storage
    property p_iso_or_wr;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && wr_take && reg_addr == ISO_OR_OFFS) |=> (mask[TYPE_ISO] == $past(reg_wdata));
    endproperty
    a_iso_or_wr: assert property (p_iso_or_wr) else $error("iso OR mask not written");

    property p_intr_or_wr;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && wr_take && reg_addr == INTR_OR_OFFS)
            |=> (mask[TYPE_INTR] == $past(reg_wdata));
    endproperty
    a_intr_or_wr: assert property (p_intr_or_wr) else $error("intr OR not written");

    property p_async_or_rd;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && rd_take && reg_addr == ASYNC_OR_OFFS)
            |=> (reg_rd_valid && reg_rdata == $past(mask[TYPE_ASYNC]));
    endproperty
    a_async_or_rd: assert property (p_async_or_rd) else $error("async OR read bad");

    property p_iso_and_hold;
        @(posedge core_clk) disable iff (!reset_n)
        !(wr_take && reg_addr == ISO_AND_OFFS) || !clk_en
            |=> $stable(mask[AND_BASE + TYPE_ISO]);
    endproperty
    a_iso_and_hold: assert property (p_iso_and_hold) else $error("iso AND changed");

    property p_intr_and_wr;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && wr_take && reg_addr == INTR_AND_OFFS) ##1 (clk_en && rd_take
            && reg_addr == INTR_AND_OFFS) |=> (reg_rdata == $past(reg_wdata, 2));
    endproperty
    a_intr_and_wr: assert property (p_intr_and_wr) else $error("intr AND write-read");

    property p_async_and_wr;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && wr_take && reg_addr == ASYNC_AND_OFFS)
            |=> (mask[AND_BASE + TYPE_ASYNC] == $past(reg_wdata));
    endproperty
    a_async_and_wr: assert property (p_async_and_wr) else $error("async AND not set");

    // Checks on evaluation and on mask readback
    property p_done_feed;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en |=> (state_r.done_map[TYPE_INTR] == $past(intr_done_map));
    endproperty
    a_done_feed: assert property (p_done_feed) else $error("done map not captured");

    property p_or_eval;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en |=> (or_hit[TYPE_ISO]
            == |($past(mask[TYPE_ISO]) & $past(state_r.done_map[TYPE_ISO])));
    endproperty
    a_or_eval: assert property (p_or_eval) else $error("iso OR group wrong");

    property p_and_eval;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && mask[AND_BASE + TYPE_ASYNC] != RDATA_NONE
            && (mask[AND_BASE + TYPE_ASYNC] & ~state_r.done_map[TYPE_ASYNC]) == RDATA_NONE)
            |=> and_hit[TYPE_ASYNC];
    endproperty
    a_and_eval: assert property (p_and_eval) else $error("async AND group missed");

    property p_and_empty;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && mask[AND_BASE + TYPE_INTR] == RDATA_NONE) |=> !and_hit[TYPE_INTR];
    endproperty
    a_and_empty: assert property (p_and_empty) else $error("empty AND group fired");

    property p_enable_gate;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !async_group_irq_enable) |=> !group_irq_req[TYPE_ASYNC];
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("async irq when off");

    property p_irq_raise;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && iso_group_irq_enable && |(mask[TYPE_ISO] & state_r.done_map[TYPE_ISO]))
            |=> group_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("iso irq missing");

    property p_intr_or_rd;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && rd_take && reg_addr == INTR_OR_OFFS)
            |=> (reg_rd_valid && reg_rdata == $past(mask[TYPE_INTR]));
    endproperty
    a_intr_or_rd: assert property (p_intr_or_rd) else $error("intr OR read bad");

    property p_iso_and_rd;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && rd_take && reg_addr == ISO_AND_OFFS)
            |=> (reg_rd_valid && reg_rdata == $past(mask[AND_BASE + TYPE_ISO]));
    endproperty
    a_iso_and_rd: assert property (p_iso_and_rd) else $error("iso AND read bad");

    property p_async_and_rd;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && rd_take && reg_addr == ASYNC_AND_OFFS)
            |=> (reg_rd_valid && reg_rdata == $past(mask[AND_BASE + TYPE_ASYNC]));
    endproperty
    a_async_and_rd: assert property (p_async_and_rd) else $error("async AND rd bad");

    property p_async_or_eval;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en |=> (or_hit[TYPE_ASYNC]
            == |($past(mask[TYPE_ASYNC]) & $past(state_r.done_map[TYPE_ASYNC])));
    endproperty
    a_async_or_eval: assert property (p_async_or_eval) else $error("async OR wrong");

    property p_iso_gate;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !iso_group_irq_enable) |=> !group_irq_req[TYPE_ISO];
    endproperty
    a_iso_gate: assert property (p_iso_gate) else $error("iso irq when off");

    property p_intr_gate;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && !intr_group_irq_enable) |=> !group_irq_req[TYPE_INTR];
    endproperty
    a_intr_gate: assert property (p_intr_gate) else $error("intr irq when off");

    property p_and_partial;
        @(posedge core_clk) disable iff (!reset_n)
        (clk_en && (mask[AND_BASE + TYPE_ISO] & ~state_r.done_map[TYPE_ISO]) != RDATA_NONE)
            |=> !and_hit[TYPE_ISO];
    endproperty
    a_and_partial: assert property (p_and_partial) else $error("iso AND early");

endmodule

/* dv/ddim_host_model.sv */
`timescale 1ns/10ps
module ddim_host_model (
    input  wire logic                        core_clk,
    output logic                             reg_cs,
    output logic                             reg_wr_en,
    output logic                             reg_rd_en,
    output logic [ddim_pkg::ADDR_W-1:0]      reg_addr,
    output logic [ddim_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic [ddim_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        reg_rd_valid
);
    import ddim_pkg::*;

    // Idle cycles before each request, for a slow host
    int gap = 0;

    initial begin
        reg_cs    = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 12'h000;
        reg_wdata = 32'h00000000;
    end

    // Released lines show the inverse, not a stale copy
    task automatic idle();
        reg_cs    = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    // Entered at a falling edge; last=0 keeps the strobe up for back to back
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input bit last = 1'b1);
        repeat (gap) @(negedge core_clk);
        reg_cs    = 1'b1;
        reg_wr_en = 1'b1;
        reg_rd_en = 1'b0;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge core_clk);
        if (last) begin
            idle();
            @(negedge core_clk);
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        int i;
        d = ~RDATA_NONE;
        repeat (gap) @(negedge core_clk);
        reg_cs    = 1'b1;
        reg_rd_en = 1'b1;
        reg_wr_en = 1'b0;
        reg_addr  = a;
        @(negedge core_clk);
        idle();
        for (i = 0; i < 4; i++) begin
            if (reg_rd_valid === 1'b1) begin
                d = reg_rdata;
                break;
            end
            @(negedge core_clk);
        end
        @(negedge core_clk);
    endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import ddim_pkg::*;

    logic                        core_clk = 1'b0;
    logic                        reset_n  = 1'b0;
    logic                        clk_en   = 1'b1;
    logic [DATA_W-1:0]           done [3] = '{32'h0, 32'h0, 32'h0};
    logic                        en   [3] = '{1'b1, 1'b1, 1'b1};
    logic                        reg_cs, reg_wr_en, reg_rd_en, reg_rd_valid, group_irq;
    logic [ADDR_W-1:0]           reg_addr;
    logic [DATA_W-1:0]           reg_wdata, reg_rdata;
    logic [NUM_TYPES-1:0]        group_irq_req;
    logic [ADDR_W-1:0]           offs [6] = '{ISO_OR_OFFS, INTR_OR_OFFS, ASYNC_OR_OFFS,
                                             ISO_AND_OFFS, INTR_AND_OFFS, ASYNC_AND_OFFS};
    logic [ADDR_W-1:0]           doffs [3] = '{ISO_DONE_OFFS, INTR_DONE_OFFS, ASYNC_DONE_OFFS};
    int                          mismatches = 0;
    int                          tests_run  = 0;
    int                          i, t, n, s;

    always #10 core_clk = ~core_clk;

    ddim_irq_masks dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_cs(reg_cs), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .iso_done_map(done[0]), .intr_done_map(done[1]), .async_done_map(done[2]),
        .iso_group_irq_enable(en[0]), .intr_group_irq_enable(en[1]),
        .async_group_irq_enable(en[2]), .group_irq_req(group_irq_req), .group_irq(group_irq));

    ddim_host_model host (.core_clk(core_clk), .reg_cs(reg_cs), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [DATA_W-1:0] pat(input int k);
        return 32'hC0000003 ^ (32'h1 << (k * 5 + 2));
    endfunction

    task automatic rdchk(input string name, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        host.rd(a, d);
        check(name, d, exp);
    endtask

    // Request path is two cycles deep; three gives margin
    task automatic irqchk(input string name, input logic [NUM_TYPES-1:0] exp);
        repeat (3) @(negedge core_clk);
        check({name, " req"}, {29'h0, group_irq_req}, {29'h0, exp});
        check({name, " any"}, {31'h0, group_irq}, {31'h0, |exp});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        mismatches++;
        results();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        for (i = 0; i < 6; i++) begin
            rdchk("mask reset", offs[i], MASK_RESET);
        end
        irqchk("irq reset", 3'h0);
        $display("test reset done");

        for (i = 0; i < 6; i++) host.wr(offs[i], pat(i), i == 5);
        host.wr(12'h340, 32'hFFFFFFFF);
        host.wr(GROUP_STATUS_OFFS, 32'hFFFFFFFF);
        clk_en = 1'b0;
        host.wr(offs[0], 32'h12345678);
        clk_en = 1'b1;
        host.gap = 2;
        for (i = 0; i < 6; i++) begin
            rdchk("mask rw", offs[i], pat(i));
        end
        rdchk("unmapped", 12'h340, RDATA_NONE);
        host.gap = 0;
        // Read taken on the edge right after the write
        host.wr(INTR_AND_OFFS, 32'h0000A5A5, 1'b0);
        rdchk("and write-read", INTR_AND_OFFS, 32'h0000A5A5);
        for (i = 0; i < 6; i++) host.wr(offs[i], MASK_RESET, i == 5);
        $display("test mask access done");

        for (t = 0; t < 3; t++) done[t] = 32'h5A000001 << t;
        // Readback shows the registered map, one edge behind the pins
        @(negedge core_clk);
        for (t = 0; t < 3; t++) rdchk("done map", doffs[t], 32'h5A000001 << t);
        for (t = 0; t < 3; t++) done[t] = 32'h0;
        $display("test done map done");

        for (t = 0; t < 3; t++) begin
            n = t * 14 + 3;
            host.wr(offs[t], 32'h1 << n);
            done[t] = 32'h1 << (n - 1);
            irqchk("or neighbour", 3'h0);
            done[t] = 32'h1 << n;
            irqchk("or hit", 3'h1 << t);
            en[t] = 1'b0;
            irqchk("or disabled", 3'h0);
            en[t] = 1'b1;
            done[t] = 32'h0;
            irqchk("or clear", 3'h0);
            host.wr(offs[t], MASK_RESET);
        end
        $display("test or group done");

        for (t = 0; t < 3; t++) begin
            n = t * 14 + 3;
            host.wr(offs[t + AND_BASE], (32'h1 << n) | 32'h1);
            done[t] = 32'h1 << n;
            irqchk("and partial", 3'h0);
            done[t] = (32'h1 << n) | 32'h1;
            irqchk("and full", 3'h1 << t);
            // AND hit and request of this type, plus the any-request bit
            s = (1 << (STAT_AND_LSB + t)) | (1 << (STAT_IRQ_LSB + t)) | (1 << STAT_ANY_BIT);
            rdchk("status", GROUP_STATUS_OFFS, s);
            en[t] = 1'b0;
            irqchk("and disabled", 3'h0);
            en[t] = 1'b1;
            host.wr(offs[t + AND_BASE], MASK_RESET);
            done[t] = 32'hFFFFFFFF;
            irqchk("and empty mask", 3'h0);
            done[t] = 32'h0;
        end
        $display("test and group done");

        host.wr(offs[5], 32'hFFFFFFFF);
        reset_n = 1'b0;
        @(negedge core_clk);
        reset_n = 1'b1;
        rdchk("mask second reset", offs[5], MASK_RESET);
        $display("test second reset done");
        results();
    end
endmodule
